// ---- verilog/monitor_interrupt_status_mirror.sv ----
// Function
// - Bit 0 flags 12 V out of limits; bit 1 second core supply.
// - Bit 4 reads one once intrusion input has gone high.
// - Bit 5 flags thermal alert pin pulled low externally, not self-driven.
// - Bit 6 flags first remote diode shorted or open.
// - Bit 7 flags second remote diode shorted or open.
// - Read-only 8-bit mirror at address 4Dh, zero at power-on.
// - Mask bit one keeps that source off the interrupt output for bits 4 to 7; bits 0 and 1 cannot be masked.
`timescale 1ns/10ps
`default_nettype none
module monitor_interrupt_status_mirror
  import status_mirror_pkg::*;
(
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        reset_n,
  // Error sources from the measurement datapath
  input  wire logic        twelve_volt_error,
  input  wire logic        second_core_supply_error,
  input  wire logic        intrusion_detect,
  input  wire logic        thermal_alert_pin_in,
  input  wire logic        thermal_alert_pin_driving,
  input  wire logic        first_remote_diode_fault,
  input  wire logic        second_remote_diode_fault,
  // Status clear and mask from the primary status logic
  input  wire logic        status_clear,
  input  wire logic [7:0]  mask_bits,
  // Register read port
  input  wire logic        reg_read,
  input  wire logic [7:0]  reg_addr,
  output logic      [7:0]  reg_rdata,
  output logic             reg_rvalid,
  // Interrupt request from this group
  output logic             int_request
);

  // Flags live in their own bank so set-against-clear priority sits in one place
  status_flag_if flags_bus ();

  status_flag_bank u_bank (
    .ref_clk (ref_clk),
    .reset_n (reset_n),
    .bank    (flags_bus.owner)
  );

  // Per-source set requests
  logic       twelve_volt_set;
  logic       second_core_set;
  logic       intrusion_set;
  logic       thermal_input_set;
  logic       first_diode_set;
  logic       second_diode_set;
  logic [7:0] set_vec;

  // Intrusion edge detector
  logic       intrusion_reg;
  logic       intrusion_next;

  // Read path
  logic       read_hit;
  logic       read_miss;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic       rvalid_reg;
  logic       rvalid_next;

  // Interrupt path
  wire logic [7:0] enable_vec;
  logic [7:0] pending_vec;
  logic       int_reg;
  logic       int_next;

  function automatic logic addr_hit(input logic [7:0] a);
    addr_hit = (a == MIRROR_ADDR);
  endfunction : addr_hit

  function automatic logic is_defined(input int idx);
    is_defined = DEFINED_BITS[idx];
  endfunction : is_defined

  function automatic logic is_maskable(input int idx);
    is_maskable = MASKABLE_BITS[idx];
  endfunction : is_maskable

  // Source conditions, one set request each
  always_comb begin
    twelve_volt_set   = twelve_volt_error;
    second_core_set   = second_core_supply_error;
    // Rising edge only; a held-high input stays latched anyway
    intrusion_set     = intrusion_detect & ~intrusion_reg;
    // Low pin while we are not driving it means an outside source
    thermal_input_set = ~thermal_alert_pin_in & ~thermal_alert_pin_driving;
    first_diode_set   = first_remote_diode_fault;
    second_diode_set  = second_remote_diode_fault;
  end

  // Bits 2 and 3 have no source and stay zero
  always_comb begin
    set_vec                    = 8'h00;
    set_vec[BIT_TWELVE_VOLT]   = twelve_volt_set;
    set_vec[BIT_SECOND_CORE]   = second_core_set;
    set_vec[BIT_INTRUSION]     = intrusion_set;
    set_vec[BIT_THERMAL_INPUT] = thermal_input_set;
    set_vec[BIT_FIRST_DIODE]   = first_diode_set;
    set_vec[BIT_SECOND_DIODE]  = second_diode_set;
  end

  assign flags_bus.set_flags = set_vec;
  assign flags_bus.clear_all = status_clear;

  // Reset level matches the idle input, so no false edge after reset
  always_comb begin
    intrusion_next = intrusion_detect;
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      intrusion_reg <= 1'b0;
    end else begin
      intrusion_reg <= intrusion_next;
    end
  end

  // A read only samples the flags, it never clears them
  always_comb begin
    read_hit    = reg_read & addr_hit(reg_addr);
    read_miss   = reg_read & ~addr_hit(reg_addr);
    rvalid_next = read_hit;
    rdata_next  = rdata_reg;
    if (read_hit) begin
      rdata_next = flags_bus.flags & DEFINED_BITS;
    end else if (read_miss) begin
      // Unmapped address returns zero rather than stale data
      rdata_next = 8'h00;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      rdata_reg  <= MIRROR_RESET;
      rvalid_reg <= 1'b0;
    end else begin
      rdata_reg  <= rdata_next;
      rvalid_reg <= rvalid_next;
    end
  end

  // The mask gates only the output; the flag itself stays visible
  for (genvar gi = 0; gi < 8; gi++) begin : g_enable
    assign enable_vec[gi] = is_defined(gi) & (~is_maskable(gi) | ~mask_bits[gi]);
  end

  always_comb begin
    pending_vec = flags_bus.flags & enable_vec;
    int_next    = |pending_vec;
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      int_reg <= 1'b0;
    end else begin
      int_reg <= int_next;
    end
  end

  // Outputs straight from their flip-flops
  assign reg_rdata   = rdata_reg;
  assign reg_rvalid  = rvalid_reg;
  assign int_request = int_reg;

endmodule : monitor_interrupt_status_mirror
`default_nettype wire

// ---- verilog/status_mirror_pkg.sv ----
package status_mirror_pkg;

  localparam logic [7:0] MIRROR_ADDR         = 8'h4D;
  localparam logic [7:0] MIRROR_RESET        = 8'h00;
  localparam logic [7:0] MASK_RESET          = 8'h00;
  localparam int         BIT_TWELVE_VOLT     = 0;
  localparam int         BIT_SECOND_CORE     = 1;
  localparam int         BIT_INTRUSION       = 4;
  localparam int         BIT_THERMAL_INPUT   = 5;
  localparam int         BIT_FIRST_DIODE     = 6;
  localparam int         BIT_SECOND_DIODE    = 7;
  localparam logic [7:0] DEFINED_BITS        = 8'hF3;
  localparam logic [7:0] MASKABLE_BITS       = 8'hF0;

endpackage : status_mirror_pkg

// ---- verilog/status_flag_if.sv ----
`timescale 1ns/10ps
`default_nettype none
interface status_flag_if;
  logic [7:0] set_flags;
  logic       clear_all;
  logic [7:0] flags;
  modport owner (input set_flags, input clear_all, output flags);
  modport user  (output set_flags, output clear_all, input flags);
endinterface : status_flag_if
`default_nettype wire

// ---- verilog/status_flag_bank.sv ----
`timescale 1ns/10ps
`default_nettype none
module status_flag_bank
  import status_mirror_pkg::*;
(
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        reset_n,
  // Flag access
  status_flag_if.owner     bank
);

  logic [7:0] flag_reg;
  logic [7:0] flag_next;

  // Set wins over a clear in the same cycle, so no event is lost
  always_comb begin
    flag_next = bank.clear_all ? MIRROR_RESET : flag_reg;
    flag_next = (flag_next | bank.set_flags) & DEFINED_BITS;
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      flag_reg <= MIRROR_RESET;
    end else begin
      flag_reg <= flag_next;
    end
  end

  assign bank.flags = flag_reg;

endmodule : status_flag_bank
`default_nettype wire

// ---- verification/mism_chk.sv ----
`timescale 1ns/10ps
`default_nettype none
module mism_chk (
  // Clock and reset
  input wire logic       ref_clk,
  input wire logic       reset_n,
  // Sources watched
  input wire logic       twelve_volt_error,
  input wire logic       first_remote_diode_fault,
  input wire logic       second_remote_diode_fault,
  input wire logic [7:0] mask_bits,
  // Register read port
  input wire logic       reg_read,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_rdata,
  input wire logic       reg_rvalid,
  // Interrupt
  input wire logic       int_request
);
  wire logic hit = reg_read&&reg_addr==8'h4D;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  sequence s_rd; hit; endsequence
  property p_hit; s_rd |=> reg_rvalid; endproperty
  a_hit: assert property(p_hit) else $error("hit");
  property p_no; !hit |=> !reg_rvalid; endproperty
  a_no: assert property(p_no) else $error("no");
  property p_zero; reg_read&&!hit |=> reg_rdata==8'h0; endproperty
  a_zero: assert property(p_zero) else $error("zero");
  property p_hold; !reg_read |=> $stable(reg_rdata); endproperty
  a_hold: assert property(p_hold) else $error("hold");
  property p_rsv; reg_rvalid |-> reg_rdata[3:2]==2'h0; endproperty
  a_rsv: assert property(p_rsv) else $error("rsv");
  property p_sup; twelve_volt_error |-> ##2 int_request; endproperty
  a_sup: assert property(p_sup) else $error("sup");
  property p_d1; first_remote_diode_fault ##1 s_rd |=> reg_rdata[6]; endproperty
  a_d1: assert property(p_d1) else $error("d1");
  property p_d2; second_remote_diode_fault ##1 s_rd |=> reg_rdata[7]; endproperty
  a_d2: assert property(p_d2) else $error("d2");
  property p_msk;
    reg_rvalid |-> int_request==|(reg_rdata&{~$past(mask_bits[7:4]),4'h3}); endproperty
  a_msk: assert property(p_msk) else $error("msk");
endmodule : mism_chk
bind monitor_interrupt_status_mirror mism_chk i_chk (
  .ref_clk                   (ref_clk),
  .reset_n                   (reset_n),
  .twelve_volt_error         (twelve_volt_error),
  .first_remote_diode_fault  (first_remote_diode_fault),
  .second_remote_diode_fault (second_remote_diode_fault),
  .mask_bits                 (mask_bits),
  .reg_read                  (reg_read),
  .reg_addr                  (reg_addr),
  .reg_rdata                 (reg_rdata),
  .reg_rvalid                (reg_rvalid),
  .int_request               (int_request)
);
`default_nettype wire

// ---- verification/host_reader.sv ----
`timescale 1ns/10ps
`default_nettype none
module host_reader(input wire logic ref_clk,reset_n,go,am,rvalid,
  input wire logic [7:0] addr,rdata,output logic rd,output logic [7:0] a,mask);
  // Idle address lines keep moving
  always_ff @(posedge ref_clk or negedge reset_n)
    if (!reset_n) {rd,a,mask} <= 17'h0;
    else {rd,a,mask} <= {go,go?addr:~a,am?mask|rdata&{8{rvalid}}&8'hF0:8'h0};
endmodule : host_reader
`default_nettype wire

// ---- verification/monitor_interrupt_status_mirror_tb.sv ----
`timescale 1ns/10ps
`default_nettype none
module monitor_interrupt_status_mirror_tb;
  logic ref_clk=0,reset_n=1,go=0,am=0,rd,rv,irq,v=0,q=0,c=0;
  logic [7:0] src=8'h0,ad=8'h0,a,mask,rdat,fl=8'h0,d=8'h0;
  int seed=32'h632E5505,err_count=0,checked=0,cyc=0;
  always #2.5 ref_clk=~ref_clk;
  monitor_interrupt_status_mirror i_dut(.ref_clk,.reset_n,.twelve_volt_error(src[0]),
    .second_core_supply_error(src[1]),.status_clear(src[2]),.thermal_alert_pin_driving(src[3]),
    .intrusion_detect(src[4]),.thermal_alert_pin_in(src[5]),.first_remote_diode_fault(src[6]),
    .second_remote_diode_fault(src[7]),.mask_bits(mask),.reg_read(rd),.reg_addr(a),
    .reg_rdata(rdat),.reg_rvalid(rv),.int_request(irq));
  host_reader i_host(.ref_clk,.reset_n,.go,.am,.rvalid(rv),.addr(ad),.rdata(rdat),.rd,.a,.mask);
  task conclude;
    $display("checked=%0d err_count=%0d",checked,err_count);
    if (err_count==0&&checked>0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : conclude
  always @(posedge ref_clk) begin
    if (++cyc>3000) begin
      err_count++;
      conclude();
    end else begin
      // Reset is asynchronous, so the outputs are already cleared at this edge
      if (!reset_n) {fl,d,v,q,c}=19'h0;
      checked++;
      if ({rv,irq,rdat}!=={v,q,d}) begin
        err_count++;
        $display("MISMATCH outputs exp %h got %h",{v,q,d},{rv,irq,rdat});
      end
      if (reset_n) begin
        v=rd&&a==8'h4D;
        if (rd) d=v?fl:8'h0;
        q=|(fl&{~mask[7:4],4'h3});
        fl=(src[2]?8'h0:fl)|
          {src[7:6],!src[5]&&!src[3],src[4]&&!c,2'h0,src[1:0]};
        c=src[4];
      end
    end
  end
  initial begin
    reset_n<=0;
    repeat (12) @(posedge ref_clk);
    reset_n<=1;
    for (int i=0; i<2000; i++) begin
      @(posedge ref_clk);
      // Second reset in mid-run must clear every flag again
      reset_n<=!(i>=1000&&i<1004);
      src<=8'($random(seed)&$random(seed));
      go<=$random(seed)%4!=0;
      ad<=$random(seed)%4!=0?8'h4D:8'($random(seed));
      am<=i[8];
    end
    conclude();
  end
endmodule : monitor_interrupt_status_mirror_tb
`default_nettype wire
